/* File: flash_write_status_reporting_tb_top.sv */
// self-checking bench: poller against the behavioural flash
`timescale 1ns/1ps
`include "fwsr_params.svh"
module flash_write_status_reporting_tb_top;
  logic        ref_clk_i   = 1'b0;
  logic        arst_n_i    = 1'b0;
  logic [3:0]  reg_addr_i  = 4'h0;
  logic [31:0] reg_wdata_i = 32'h0;
  logic        reg_wr_i    = 1'b0;
  logic        reg_rd_i    = 1'b0;
  logic [31:0] reg_rdata_o;
  logic [31:0] rd_val;
  logic [21:0] fl_addr_o;
  logic [7:0]  host_dq;
  logic [7:0]  flash_dq;
  logic [7:0]  dq_bus;
  logic        dq_oe_o;
  logic        fl_ce_n_o;
  logic        fl_oe_n_o;
  logic        fl_we_n_o;
  logic        busy_o;
  logic        rb_n;
  logic        clk_en          = 1'b1;
  int          fail_count      = 0;
  int          samples_checked = 0;
  assign dq_bus = dq_oe_o ? host_dq : flash_dq;
  fwsr_poller #(.RD_CYC(2), .WR_CYC(2)) u_fwsr_poller (
    .ref_clk_i(ref_clk_i), .arst_n_i(arst_n_i), .clk_en_i(clk_en),
    .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i),
    .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i), .reg_rdata_o(reg_rdata_o),
    .dq_i(dq_bus), .ready_busy_n_pin_i(rb_n), .fl_addr_o(fl_addr_o),
    .dq_o(host_dq), .dq_oe_o(dq_oe_o), .fl_ce_n_o(fl_ce_n_o),
    .fl_oe_n_o(fl_oe_n_o), .fl_we_n_o(fl_we_n_o), .busy_o(busy_o));
  fwsr_flash_model u_fwsr_flash_model (
    .ce_n_i(fl_ce_n_o), .oe_n_i(fl_oe_n_o), .we_n_i(fl_we_n_o),
    .dq_i(dq_bus), .dq_o(flash_dq), .ready_busy_n_pin_o(rb_n));
  initial begin
    forever #2.5 ref_clk_i = ~ref_clk_i;
  end
  ////////////////////////////////////////////////////////////////////////////
  task automatic chk(input logic [31:0] got, input logic [31:0] exp,
                     input string msg);
    samples_checked++;
    if (got !== exp) begin
      fail_count++;
      $display("ERROR %0t %s got %h exp %h", $time, msg, got, exp);
    end
  endtask
  task automatic reg_wr(input logic [3:0] a, input logic [31:0] d);
    @(posedge ref_clk_i);
    reg_wr_i    <= 1'b1;
    reg_addr_i  <= a;
    reg_wdata_i <= d;
    @(posedge ref_clk_i);
    reg_wr_i    <= 1'b0;
  endtask
  task automatic reg_rd(input logic [3:0] a);
    @(posedge ref_clk_i);
    reg_rd_i   <= 1'b1;
    reg_addr_i <= a;
    @(posedge ref_clk_i);
    reg_rd_i   <= 1'b0;
    #1 rd_val = reg_rdata_o;
  endtask
  task automatic start_op(input logic erase, input logic [7:0] data,
                          input int reads, input logic fail);
    u_fwsr_flash_model.begin_op(erase, data, reads, fail);
    reg_wr(`FWSR_REG_ADDR, 32'h0012345);
    reg_wr(`FWSR_REG_DATA, {24'h0, data});
    reg_wr(`FWSR_REG_CTRL, {30'h0, erase, 1'b1});
    // busy_o follows the state one edge late: let it rise first
    repeat (2) @(posedge ref_clk_i);
  endtask
  // bounded wait: a poller stuck in its loop must not hang the run
  task automatic wait_done;
    int n;
    n = 0;
    while (busy_o !== 1'b0 && n < 4000) begin
      @(posedge ref_clk_i);
      n++;
    end
    chk(n < 4000, 1'b1, "poll did not finish");
  endtask
  // clock enable low must hold chip enable, output enable and the busy flag
  task automatic freeze_check;
    logic [2:0] snap;
    @(posedge ref_clk_i);
    clk_en <= 1'b0;
    @(posedge ref_clk_i);
    #1 snap = {fl_ce_n_o, fl_oe_n_o, busy_o};
    repeat (8) @(posedge ref_clk_i);
    #1 chk({fl_ce_n_o, fl_oe_n_o, busy_o}, snap, "frozen outputs");
    @(posedge ref_clk_i);
    clk_en <= 1'b1;
  endtask
  ////////////////////////////////////////////////////////////////////////////
  task automatic t_reset;
    chk({fl_ce_n_o, fl_oe_n_o, fl_we_n_o, dq_oe_o, busy_o}, 5'b11100, "idle");
    reg_rd(4'hF);
    chk(rd_val, 32'h0, "unmapped read");
    $display("test reset done");
  endtask
  task automatic t_program;
    start_op(1'b0, 8'h5A, 4, 1'b0);
    wait_done;
    reg_rd(`FWSR_REG_STAT);
    chk(rd_val[1:0], 2'b01, "program status");
    reg_rd(`FWSR_REG_LAST);
    chk(rd_val[7:0], 8'h5A, "program byte");
    $display("test program done");
  endtask
  task automatic t_erase;
    start_op(1'b1, 8'hFF, 3, 1'b0);
    wait_done;
    reg_rd(`FWSR_REG_STAT);
    chk(rd_val[1:0], 2'b01, "erase status");
    reg_rd(`FWSR_REG_LAST);
    chk(rd_val[7:0], 8'hFF, "erase byte");
    $display("test erase done");
  endtask
  task automatic t_idle;
    start_op(1'b0, 8'hC3, 0, 1'b0);
    wait_done;
    reg_rd(`FWSR_REG_STAT);
    chk({rd_val[8], rd_val[3], rd_val[1:0]}, 4'b1001, "ready");
    $display("test idle done");
  endtask
  task automatic t_fail;
    start_op(1'b0, 8'h5A, 2, 1'b1);
    wait_done;
    reg_rd(`FWSR_REG_STAT);
    chk(rd_val[1], 1'b1, "fail flag");
    chk(u_fwsr_flash_model.rst_cmds, 32'h1, "reset cmds");
    reg_rd(`FWSR_REG_LAST);
    chk(rd_val[5], 1'b1, "timeout bit");
    $display("test fail done");
  endtask
  task automatic t_busy;
    start_op(1'b0, 8'h3C, 20, 1'b0);
    repeat (30) @(posedge ref_clk_i);
    reg_rd(`FWSR_REG_STAT);
    chk({rd_val[8], rd_val[3]}, 2'b01, "busy status");
    reg_wr(`FWSR_REG_ADDR, 32'h03FFFFF);
    reg_rd(`FWSR_REG_ADDR);
    chk(rd_val, 32'h00012345, "address reg write refused");
    chk(fl_addr_o, 22'h012345, "address write refused");
    freeze_check;
    wait_done;
    reg_rd(`FWSR_REG_STAT);
    chk(rd_val[1:0], 2'b01, "long program status");
    $display("test busy done");
  endtask
  task automatic t_suspend;
    u_fwsr_flash_model.suspend_op;
    reg_wr(`FWSR_REG_CTRL, 32'h00000003);
    repeat (2) @(posedge ref_clk_i);
    wait_done;
    reg_rd(`FWSR_REG_CTRL);
    chk(rd_val, 32'h00000002, "erase mode readback");
    reg_rd(`FWSR_REG_STAT);
    chk({rd_val[8], rd_val[3], rd_val[1:0]}, 4'b1001, "susp");
    reg_rd(`FWSR_REG_LAST);
    chk(rd_val[23:7], 17'h00003, "suspend poll count");
    $display("test suspend done");
  endtask
  ////////////////////////////////////////////////////////////////////////////
  task automatic end_sim;
    $display("checks %0d mismatches %0d", samples_checked, fail_count);
    if (fail_count == 0 && samples_checked > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  initial begin
    repeat (20000) @(posedge ref_clk_i);
    fail_count++;
    $display("ERROR %0t watchdog expired", $time);
    end_sim;
  end
  initial begin
    repeat (5) @(posedge ref_clk_i);
    arst_n_i <= 1'b1;
    @(posedge ref_clk_i);
    t_reset;
    t_program;
    t_erase;
    t_idle;
    t_fail;
    t_busy;
    t_suspend;
    end_sim;
  end
endmodule

/* File: fwsr_bus_cycle.sv */
// one asynchronous flash bus cycle: read or write with fixed strobe width
`timescale 1ns/1ps
`include "fwsr_params.svh"
module fwsr_bus_cycle #(
  parameter int RD_CYC = `FWSR_RD_CYC,
  parameter int WR_CYC = `FWSR_WR_CYC
) (
  input  wire logic        ref_clk_i,
  input  wire logic        arst_n_i,
  input  wire logic        ce_i,
  input  wire logic        start_i,
  input  wire logic        write_i,
  input  wire logic [7:0]  wdata_i,
  input  wire logic [7:0]  dq_sync_i,
  output logic             busy_o,
  output logic             done_o,
  output logic [7:0]       rdata_o,
  output logic             ce_n_o,
  output logic             oe_n_o,
  output logic             we_n_o,
  output logic [7:0]       dq_o,
  output logic             dq_oe_o
);
  logic [7:0] cnt_q;
  logic       wr_q;
  // sample after strobe width plus two sync stages, so data is settled
  wire  [7:0] limit = wr_q ? 8'(WR_CYC) : 8'(RD_CYC + 2);
  wire        last  = busy_o && (cnt_q == limit);

  always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      cnt_q   <= 8'h00;
      wr_q    <= 1'b0;
      busy_o  <= 1'b0;
      done_o  <= 1'b0;
      rdata_o <= 8'h00;
      ce_n_o  <= 1'b1;
      oe_n_o  <= 1'b1;
      we_n_o  <= 1'b1;
      dq_o    <= 8'h00;
      dq_oe_o <= 1'b0;
    end else if (ce_i) begin
      done_o <= 1'b0;
      if (start_i && !busy_o) begin
        busy_o  <= 1'b1;
        wr_q    <= write_i;
        cnt_q   <= 8'h00;
        ce_n_o  <= 1'b0;
        oe_n_o  <= write_i;
        we_n_o  <= !write_i;
        dq_o    <= wdata_i;
        dq_oe_o <= write_i;
      end else if (last) begin
        // both strobes rise together: the device counts one access
        busy_o  <= 1'b0;
        done_o  <= 1'b1;
        ce_n_o  <= 1'b1;
        oe_n_o  <= 1'b1;
        we_n_o  <= 1'b1;
        dq_oe_o <= 1'b0;
        if (!wr_q) begin
          rdata_o <= dq_sync_i;
        end
      end else if (busy_o) begin
        cnt_q <= cnt_q + 8'h01;
      end
    end
  end
endmodule

/* File: fwsr_flash_model.sv */
// behavioural flash device answering the poller's status reads
`timescale 1ns/1ps
module fwsr_flash_model (
  input  wire logic       ce_n_i,
  input  wire logic       oe_n_i,
  input  wire logic       we_n_i,
  input  wire logic [7:0] dq_i,
  output logic [7:0]      dq_o,
  output logic            ready_busy_n_pin_o
);
  int         left_q   = 0;
  int         rst_cmds = 0;
  logic       erase_q  = 1'b0;
  logic       fail_q   = 1'b0;
  logic       tog_q    = 1'b0;
  logic       acc_q    = 1'b0;
  logic [7:0] data_q   = 8'hFF;
  logic [7:0] last_q   = 8'h00;
  logic [7:0] wr_q     = 8'h00;
  logic       susp_q   = 1'b0;
  logic       sect_q   = 1'b0;
  logic       shows;
  logic       busy;
  logic       rd_on;
  logic [7:0] stat;
  // status is live at once; protected targets are a short busy window
  // a partly protected erase behaves as a plain erase here
  task automatic begin_op(input logic erase, input logic [7:0] data,
                          input int reads, input logic fail);
    susp_q  = 1'b0;
    erase_q = erase;
    data_q  = data;
    left_q  = reads;
    fail_q  = fail;
  endtask
  // erase suspended: ready pin high, bit 7 high, bit 6 frozen
  task automatic suspend_op;
    erase_q = 1'b1;
    susp_q  = 1'b1;
    left_q  = 0;
    fail_q  = 1'b0;
  endtask
  ////////////////////////////////////////////////////////////////////////////
  assign rd_on = !ce_n_i && !oe_n_i;
  assign busy  = (left_q > 0) || fail_q;
  assign shows = busy || susp_q;
  assign stat  = {erase_q ? susp_q : ~data_q[7], tog_q, fail_q, 2'b00,
                  erase_q & sect_q, 2'b00};
  // a released bus shows the inverse byte so a stale value never matches
  assign dq_o  = rd_on ? (shows ? stat : data_q) : ~last_q;
  assign ready_busy_n_pin_o = !busy;
  always @(rd_on) begin
    if (rd_on) begin
      acc_q = 1'b1;
    end else if (acc_q) begin
      acc_q  = 1'b0;
      last_q = shows ? stat : data_q;
      if (busy) begin
        tog_q = ~tog_q;
      end
      if (shows) begin
        sect_q = ~sect_q;
      end
      if (left_q > 0) begin
        left_q--;
      end
    end
  end
  // latch well inside the pulse: the host drops its drive as we_n rises
  always @(negedge we_n_i) begin
    #1;
    if (!ce_n_i) begin
      wr_q = dq_i;
    end
  end
  always @(posedge we_n_i) begin
    if (wr_q == 8'hF0) begin
      fail_q = 1'b0;
      left_q = 0;
      rst_cmds++;
    end
  end
endmodule

/* File: fwsr_params.svh */
// constants for the flash status poller: pin timing, bit positions, commands
`ifndef FWSR_PARAMS_SVH
`define FWSR_PARAMS_SVH
`define FWSR_CLK_MHZ        200
`define FWSR_RD_NS          100
`define FWSR_RD_CYC         ((`FWSR_RD_NS * `FWSR_CLK_MHZ + 999) / 1000)
`define FWSR_WR_NS          60
`define FWSR_WR_CYC         ((`FWSR_WR_NS * `FWSR_CLK_MHZ + 999) / 1000)
`define FWSR_BIT_POLL       7
`define FWSR_BIT_ACT        6
`define FWSR_BIT_FAIL       5
`define FWSR_BIT_SECT       2
`define FWSR_RESET_CMD      8'hF0
`define FWSR_REG_CTRL       4'h0
`define FWSR_REG_ADDR       4'h1
`define FWSR_REG_DATA       4'h2
`define FWSR_REG_STAT       4'h3
`define FWSR_REG_LAST       4'h4
`define FWSR_CTRL_GO        0
`define FWSR_CTRL_ERASE     1
`define FWSR_CTRL_MAXPOLL   16'hFFFF
`endif

/* File: fwsr_pkg.sv */
// types for the flash status poller
package fwsr_pkg;
  typedef enum logic [3:0] {
    FWSR_IDLE, FWSR_RD1, FWSR_RD2, FWSR_EVAL, FWSR_RD3, FWSR_EVAL3,
    FWSR_RST, FWSR_DONE, FWSR_FAIL
  } fwsr_state_t;
endpackage

/* File: fwsr_poller.sv */
// host poller: runs toggle and complement polling on a flash status read
`timescale 1ns/1ps
`include "fwsr_params.svh"
////////////////////////////////////////////////////////////////////////////////
// Functional notes
// - poll reads use the program address
// - erase poll reads stay inside erased sector
// - read once more after bit 7 turns true
// - two back-to-back reads, compare toggle bit
// - toggling plus fail bit: recheck, then reset
// - restart polling from first step on return
module fwsr_poller #(
  parameter int RD_CYC = `FWSR_RD_CYC,
  parameter int WR_CYC = `FWSR_WR_CYC
) (
  input  wire logic        ref_clk_i,
  input  wire logic        arst_n_i,
  input  wire logic        clk_en_i,
  input  wire logic [3:0]  reg_addr_i,
  input  wire logic [31:0] reg_wdata_i,
  input  wire logic        reg_wr_i,
  input  wire logic        reg_rd_i,
  output logic      [31:0] reg_rdata_o,
  input  wire logic [7:0]  dq_i,
  input  wire logic        ready_busy_n_pin_i,
  output logic [21:0]      fl_addr_o,
  output logic [7:0]       dq_o,
  output logic             dq_oe_o,
  output logic             fl_ce_n_o,
  output logic             fl_oe_n_o,
  output logic             fl_we_n_o,
  output logic             busy_o
);
  ////////////////////////////////////////////////////////////////////////////
  // pin synchronisers
  logic [7:0] dq_s1_q;
  logic [7:0] dq_s2_q;
  logic       rb_s1_q;
  logic       rb_s2_q;
  always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      dq_s1_q <= 8'h00;
      dq_s2_q <= 8'h00;
      rb_s1_q <= 1'b1;
      rb_s2_q <= 1'b1;
    end else if (clk_en_i) begin
      dq_s1_q <= dq_i;
      dq_s2_q <= dq_s1_q;
      rb_s1_q <= ready_busy_n_pin_i;
      rb_s2_q <= rb_s1_q;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // registers and state
  fwsr_pkg::fwsr_state_t st_q;
  logic [21:0] addr_q;
  logic [7:0]  exp_q;
  logic        erase_q;
  logic [7:0]  first_q;
  logic [7:0]  last_q;
  logic [15:0] polls_q;
  logic        done_q;
  logic        fail_q;
  logic        cyc_start_q;
  logic        cyc_wr_q;
  logic        cyc_busy;
  logic        cyc_done;
  logic [7:0]  cyc_rdata;

  wire go_wr   = reg_wr_i && (reg_addr_i == `FWSR_REG_CTRL) &&
                 reg_wdata_i[`FWSR_CTRL_GO];
  wire idle    = (st_q == fwsr_pkg::FWSR_IDLE) ||
                 (st_q == fwsr_pkg::FWSR_DONE) ||
                 (st_q == fwsr_pkg::FWSR_FAIL);
  // toggle bit compare of first_q with the latest read: back-to-back except in EVAL3 after a clean EVAL (first and third read)
  wire act_tgl  = first_q[`FWSR_BIT_ACT] != cyc_rdata[`FWSR_BIT_ACT];
  wire fail_bit = first_q[`FWSR_BIT_FAIL];
  // erase complement polling reads 1 when erase is done
  wire poll_ok  = erase_q ? cyc_rdata[`FWSR_BIT_POLL] :
                  (cyc_rdata[`FWSR_BIT_POLL] == exp_q[`FWSR_BIT_POLL]);
  wire cap_now  = cyc_done && !cyc_wr_q;

  always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      addr_q  <= 22'h000000;
      exp_q   <= 8'h00;
      erase_q <= 1'b0;
    end else if (clk_en_i && reg_wr_i && idle) begin
      if (reg_addr_i == `FWSR_REG_ADDR) begin
        addr_q <= reg_wdata_i[21:0];
      end
      if (reg_addr_i == `FWSR_REG_DATA) begin
        exp_q <= reg_wdata_i[7:0];
      end
      if (reg_addr_i == `FWSR_REG_CTRL) begin
        erase_q <= reg_wdata_i[`FWSR_CTRL_ERASE];
      end
    end
  end

  always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      st_q        <= fwsr_pkg::FWSR_IDLE;
      first_q     <= 8'h00;
      last_q      <= 8'h00;
      polls_q     <= 16'h0000;
      done_q      <= 1'b0;
      fail_q      <= 1'b0;
      cyc_start_q <= 1'b0;
      cyc_wr_q    <= 1'b0;
    end else if (clk_en_i) begin
      cyc_start_q <= 1'b0;
      unique case (st_q)
        fwsr_pkg::FWSR_IDLE, fwsr_pkg::FWSR_DONE, fwsr_pkg::FWSR_FAIL: begin
          if (go_wr) begin
            // a new run always starts at the first read
            st_q        <= fwsr_pkg::FWSR_RD1;
            polls_q     <= 16'h0000;
            done_q      <= 1'b0;
            fail_q      <= 1'b0;
            cyc_wr_q    <= 1'b0;
            cyc_start_q <= 1'b1;
          end
        end
        fwsr_pkg::FWSR_RD1: begin
          if (cap_now) begin
            first_q     <= cyc_rdata;
            st_q        <= fwsr_pkg::FWSR_RD2;
            cyc_start_q <= 1'b1;
          end
        end
        fwsr_pkg::FWSR_RD2: begin
          if (cap_now) begin
            last_q <= cyc_rdata;
            st_q   <= fwsr_pkg::FWSR_EVAL;
          end
        end
        fwsr_pkg::FWSR_EVAL: begin
          polls_q <= polls_q + 16'h0001;
          if (!act_tgl && poll_ok) begin
            // trust data only from one more read
            st_q        <= fwsr_pkg::FWSR_RD3;
            cyc_start_q <= 1'b1;
          end else if (fail_bit || polls_q == `FWSR_CTRL_MAXPOLL) begin
            st_q        <= fwsr_pkg::FWSR_RD3;
            cyc_start_q <= 1'b1;
            first_q     <= last_q;
          end else begin
            st_q        <= fwsr_pkg::FWSR_RD1;
            cyc_start_q <= 1'b1;
          end
        end
        fwsr_pkg::FWSR_RD3: begin
          if (cap_now) begin
            last_q <= cyc_rdata;
            st_q   <= fwsr_pkg::FWSR_EVAL3;
          end
        end
        fwsr_pkg::FWSR_EVAL3: begin
          if (!act_tgl) begin
            st_q   <= fwsr_pkg::FWSR_DONE;
            done_q <= 1'b1;
          end else begin
            // still toggling at the confirming read: reset the device
            st_q        <= fwsr_pkg::FWSR_RST;
            cyc_wr_q    <= 1'b1;
            cyc_start_q <= 1'b1;
          end
        end
        fwsr_pkg::FWSR_RST: begin
          if (cyc_done) begin
            st_q     <= fwsr_pkg::FWSR_FAIL;
            fail_q   <= 1'b1;
            cyc_wr_q <= 1'b0;
          end
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // register read port
  wire [31:0] stat_w = {20'h00000, 3'h0, rb_s2_q, 4'h0,
                        idle ? 1'b0 : 1'b1, 1'b0, fail_q, done_q};
  wire [31:0] rd_mux =
    (reg_addr_i == `FWSR_REG_CTRL) ? {30'h00000000, erase_q, 1'b0} :
    (reg_addr_i == `FWSR_REG_ADDR) ? {10'h000, addr_q} :
    (reg_addr_i == `FWSR_REG_DATA) ? {24'h000000, exp_q} :
    (reg_addr_i == `FWSR_REG_STAT) ? stat_w :
    (reg_addr_i == `FWSR_REG_LAST) ? {8'h00, polls_q, last_q} :
    32'h00000000;
  always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      reg_rdata_o <= 32'h00000000;
      fl_addr_o   <= 22'h000000;
      busy_o      <= 1'b0;
    end else if (clk_en_i) begin
      reg_rdata_o <= reg_rd_i ? rd_mux : 32'h00000000;
      fl_addr_o   <= addr_q;
      busy_o      <= !idle;
    end
  end

  fwsr_bus_cycle #(
    .RD_CYC (RD_CYC),
    .WR_CYC (WR_CYC)
  ) u_cycle (
    .ref_clk_i (ref_clk_i),
    .arst_n_i  (arst_n_i),
    .ce_i      (clk_en_i),
    .start_i   (cyc_start_q),
    .write_i   (cyc_wr_q),
    .wdata_i   (`FWSR_RESET_CMD),
    .dq_sync_i (dq_s2_q),
    .busy_o    (cyc_busy),
    .done_o    (cyc_done),
    .rdata_o   (cyc_rdata),
    .ce_n_o    (fl_ce_n_o),
    .oe_n_o    (fl_oe_n_o),
    .we_n_o    (fl_we_n_o),
    .dq_o      (dq_o),
    .dq_oe_o   (dq_oe_o)
  );

  ////////////////////////////////////////////////////////////////////////////
  // checks
  sequence s_fail_seen;
    st_q == fwsr_pkg::FWSR_EVAL3 && act_tgl;
  endsequence
  AST_RESET_AFTER_TOGGLE: assert property (
    @(posedge ref_clk_i) disable iff (!arst_n_i)
    s_fail_seen and clk_en_i |=> st_q == fwsr_pkg::FWSR_RST)
    else $error("no reset command after persistent toggle");
  AST_TWO_READS: assert property (
    @(posedge ref_clk_i) disable iff (!arst_n_i)
    // only the entry into evaluation: a frozen clock may hold the state
    st_q == fwsr_pkg::FWSR_EVAL && $past(st_q) != fwsr_pkg::FWSR_EVAL
    |-> $past(st_q) == fwsr_pkg::FWSR_RD2)
    else $error("evaluation without two reads");
  AST_EXTRA_READ: assert property (
    @(posedge ref_clk_i) disable iff (!arst_n_i)
    $rose(done_q) |-> $past(st_q) == fwsr_pkg::FWSR_EVAL3)
    else $error("done without confirming read");
  AST_ADDR_STABLE: assert property (
    @(posedge ref_clk_i) disable iff (!arst_n_i)
    !fl_ce_n_o && !idle |-> fl_addr_o == addr_q)
    else $error("poll address moved");
  AST_RESET_CMD: assert property (
    @(posedge ref_clk_i) disable iff (!arst_n_i)
    !fl_we_n_o |-> dq_oe_o && dq_o == `FWSR_RESET_CMD)
    else $error("bad reset command");
  AST_RESTART: assert property (
    @(posedge ref_clk_i) disable iff (!arst_n_i)
    idle && go_wr && clk_en_i |=> st_q == fwsr_pkg::FWSR_RD1)
    else $error("poll not restarted at first step");
  AST_FAIL_FLAG: assert property (
    @(posedge ref_clk_i) disable iff (!arst_n_i)
    $rose(fail_q) |-> $past(st_q) == fwsr_pkg::FWSR_RST)
    else $error("fail flag without reset write");
  AST_ACCESS_END: assert property (
    @(posedge ref_clk_i) disable iff (!arst_n_i)
    cyc_done |-> fl_ce_n_o && fl_oe_n_o)
    else $error("access not ended");
  AST_START_IDLE: assert property (
    @(posedge ref_clk_i) disable iff (!arst_n_i)
    cyc_start_q |-> !cyc_busy)
    else $error("access started while one is open");
endmodule
